// ---- pkg/ee_consts.svh ----
// Constants of the serial EEPROM slave: geometry, opcodes, timing, reset values
`ifndef EE_CONSTS_SVH
`define EE_CONSTS_SVH

`define EE_ADDR_W       14
`define EE_PAGE_W       6
`define EE_FIELD_W      16
`define EE_OP_READ      8'h03
`define EE_OP_WRITE     8'h02
`define EE_OP_CLR_LATCH 8'h04
`define EE_OP_SET_LATCH 8'h06
`define EE_OP_STAT_RD   8'h05
`define EE_OP_STAT_WR   8'h01
`define EE_BYTE_SAT     3'h4
`define EE_NV_RST       3'h0
`define EE_CLK_NS       4
`define EE_TWC_MS       5
`define EE_TWC_CYC      ((`EE_TWC_MS * 1000000) / `EE_CLK_NS)
`define EE_CNT_W        21

`endif

// ---- pkg/ee_pkg.sv ----
// Types shared by the serial EEPROM slave
`default_nettype none
package ee_pkg;

  typedef enum logic [4:0] {
    CMD_NONE   = 5'h01,
    CMD_SET    = 5'h02,
    CMD_CLR    = 5'h04,
    CMD_STATUS = 5'h08,
    CMD_ARRAY  = 5'h10
  } cmd_type;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_COPY = 3'h2,
    ST_WAIT = 3'h4
  } core_state_type;

  typedef struct packed {
    logic       protect_pin_enable;
    logic [2:0] spare;
    logic       block_protect_high;
    logic       block_protect_low;
    logic       write_latch_flag;
    logic       write_busy_flag;
  } status_type;

endpackage
`default_nettype wire

// ---- rtl/spi_serial_eeprom_interface.sv ----
// Serial EEPROM slave: serial shifter on the serial clock, array and write timer on core clock
`default_nettype none
`include "ee_consts.svh"
module spi_serial_eeprom_interface #(
  parameter int unsigned ADDR_W     = `EE_ADDR_W,
  parameter int unsigned PAGE_W     = `EE_PAGE_W,
  parameter int unsigned TWC_CYCLES = `EE_TWC_CYC
) (
  input  wire logic          core_clk_i, // Core clock, 250 MHz
  input  wire logic          rst_i,      // Reset, active high; synchronous in the core domain, asynchronous for the serial-side results
  input  wire logic          sck_i,      // Serial clock from master
  input  wire logic          cs_n_i,     // Chip select, active low
  input  wire logic          si_i,       // Serial data in
  input  wire logic          hold_n_i,   // Pause, active low
  input  wire logic          wp_n_i,     // Write protect, active low
  output logic               so_o,       // Serial data out
  output logic               so_oe_n_o,  // Serial out enable, low while driving
  output ee_pkg::status_type status_o    // Status register image
);
  import ee_pkg::*;

  localparam int unsigned PAGE_BYTES = 1 << PAGE_W;
  localparam int unsigned BASE_W     = ADDR_W - PAGE_W;
  localparam int unsigned BUSY_MAX   = PAGE_BYTES + TWC_CYCLES + 2;

  if (ADDR_W > `EE_FIELD_W - 2 || ADDR_W < PAGE_W + 2 || PAGE_W < 1) begin : g_bad_geom
    $error("Unsupported array geometry");
  end
  if (TWC_CYCLES < 1 || TWC_CYCLES >= (1 << `EE_CNT_W)) begin : g_bad_twc
    $error("Write cycle count out of range");
  end

  // Array and page buffer
  logic [7:0]              mem_r  [0:(1 << ADDR_W) - 1];
  logic [7:0]              pbuf_r [0:PAGE_BYTES - 1];
  logic [PAGE_BYTES - 1:0] pmask_r;

  // Serial clock domain, frame state cleared by deselect
  logic [2:0]  bit_r;
  logic [2:0]  byte_r;
  logic [7:0]  sh_r;
  logic [7:0]  op_r;
  logic        op_ok_r;
  logic        rd_ok_r;
  logic        wr_ok_r;
  logic        pos_tgl_r;
  logic        neg_tgl_r;
  logic        drive_r;
  logic [7:0]  out_sh_r;
  logic        arm_s1_r;
  logic        arm_s2_r;
  logic        busy_s1_r;
  logic        busy_s2_r;
  status_type  st_s1_r;
  status_type  st_s2_r;

  // Serial clock domain, results kept for the core after deselect
  cmd_type               kind_r;
  logic                  tag_r;
  logic [15:0]           addr_r;
  logic [7:0]            sr_byte_r;
  logic [BASE_W - 1:0]   wr_base_r;
  logic [PAGE_W - 1:0]   wr_off_r;
  logic [ADDR_W - 1:0]   rd_addr_r;
  logic                  rd_tgl_r;

  // Core domain
  logic                  cs_s1_r;
  logic                  cs_s2_r;
  logic                  cs_s3_r;
  logic                  wp_s1_r;
  logic                  wp_s2_r;
  logic                  tag_s1_r;
  logic                  tag_s2_r;
  logic                  tag_seen_r;
  logic                  rd_s1_r;
  logic                  rd_s2_r;
  logic                  rd_s3_r;
  logic [7:0]            rd_data_r;
  logic                  hi_seen_r;
  logic                  arm_r;
  logic                  wp_low_r;
  core_state_type        state_r;
  logic [`EE_CNT_W-1:0]  cnt_r;
  logic [PAGE_W - 1:0]   off_r;
  logic                  wel_r;
  logic                  protect_pin_enable_r;
  logic [1:0]            bp_r;

  logic        byte_done;
  logic [7:0]  sh_nxt;
  logic [15:0] addr_nxt;
  logic        op_valid;
  logic        cs_rise;
  logic        cs_fall;
  logic        new_frame;
  logic        go;
  logic        prot;
  logic        wp_cancel;
  logic        busy;

  assign sh_nxt    = {sh_r[6:0], si_i};
  assign addr_nxt  = {addr_r[14:0], si_i};
  assign byte_done = (bit_r == 3'h7);
  assign op_valid  = arm_s2_r && (sh_nxt == `EE_OP_READ || sh_nxt == `EE_OP_WRITE
                     || sh_nxt == `EE_OP_SET_LATCH || sh_nxt == `EE_OP_CLR_LATCH
                     || sh_nxt == `EE_OP_STAT_RD || sh_nxt == `EE_OP_STAT_WR);

  // Bit and byte position; rising edges during pause are not counted
  always_ff @(posedge sck_i or posedge cs_n_i) begin
    if (cs_n_i) begin
      bit_r     <= 3'h0;
      byte_r    <= 3'h0;
      sh_r      <= 8'h00;
      op_r      <= 8'h00;
      op_ok_r   <= 1'b0;
      rd_ok_r   <= 1'b0;
      wr_ok_r   <= 1'b0;
      pos_tgl_r <= 1'b0;
    end else if (hold_n_i) begin
      sh_r      <= sh_nxt;
      bit_r     <= bit_r + 3'h1;
      pos_tgl_r <= ~pos_tgl_r;
      if (byte_done) begin
        if (byte_r != `EE_BYTE_SAT) begin
          byte_r <= byte_r + 3'h1;
        end
        if (byte_r == 3'h0) begin
          op_r    <= sh_nxt;
          op_ok_r <= op_valid;
        end
        if (byte_r == 3'h2 && op_ok_r) begin
          rd_ok_r <= (op_r == `EE_OP_READ) && !busy_s2_r;
          wr_ok_r <= (op_r == `EE_OP_WRITE) && !busy_s2_r;
        end
      end
    end
  end

  // Level crossings into the serial domain; only the second stage is read
  always_ff @(posedge sck_i or posedge cs_n_i) begin
    if (cs_n_i) begin
      arm_s1_r  <= 1'b0;
      arm_s2_r  <= 1'b0;
      busy_s1_r <= 1'b0;
      busy_s2_r <= 1'b0;
      st_s1_r   <= '0;
      st_s2_r   <= '0;
    end else begin
      arm_s1_r  <= arm_r;
      arm_s2_r  <= arm_s1_r;
      busy_s1_r <= busy;
      busy_s2_r <= busy_s1_r;
      st_s1_r   <= status_o;
      st_s2_r   <= st_s1_r;
    end
  end

  // Command outcome held past deselect so the core can act on it
  always_ff @(posedge sck_i or posedge rst_i) begin
    if (rst_i) begin
      kind_r    <= CMD_NONE;
      tag_r     <= 1'b0;
      addr_r    <= 16'h0000;
      sr_byte_r <= 8'h00;
      wr_base_r <= '0;
      wr_off_r  <= '0;
      rd_addr_r <= '0;
      rd_tgl_r  <= 1'b0;
      pmask_r   <= '0;
    end else if (!cs_n_i && hold_n_i) begin
      if (bit_r == 3'h0 && byte_r == 3'h0) begin
        tag_r <= ~tag_r;
      end
      kind_r <= CMD_NONE;
      if (byte_r == 3'h1 || byte_r == 3'h2) begin
        addr_r <= addr_nxt;
      end
      if (byte_done) begin
        if (byte_r == 3'h0 && op_valid && sh_nxt == `EE_OP_SET_LATCH) begin
          kind_r <= CMD_SET;
        end
        if (byte_r == 3'h0 && op_valid && sh_nxt == `EE_OP_CLR_LATCH) begin
          kind_r <= CMD_CLR;
        end
        if (byte_r == 3'h1 && op_ok_r && op_r == `EE_OP_STAT_WR) begin
          kind_r    <= CMD_STATUS;
          sr_byte_r <= sh_nxt;
        end
        if (byte_r == 3'h2 && op_ok_r && op_r == `EE_OP_WRITE && !busy_s2_r) begin
          wr_base_r <= addr_nxt[ADDR_W - 1:PAGE_W];
          wr_off_r  <= addr_nxt[PAGE_W - 1:0];
          pmask_r   <= '0;
        end
        if (byte_r == 3'h2 && op_ok_r && op_r == `EE_OP_READ && !busy_s2_r) begin
          rd_addr_r <= addr_nxt[ADDR_W - 1:0];
          rd_tgl_r  <= ~rd_tgl_r;
        end
        if (byte_r >= 3'h3 && rd_ok_r) begin
          rd_addr_r <= rd_addr_r + 1'b1;
          rd_tgl_r  <= ~rd_tgl_r;
        end
        if (byte_r >= 3'h3 && wr_ok_r) begin
          kind_r            <= CMD_ARRAY;
          wr_off_r          <= wr_off_r + 1'b1;
          pmask_r[wr_off_r] <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge sck_i) begin
    if (!cs_n_i && hold_n_i && byte_done && byte_r >= 3'h3 && wr_ok_r) begin
      pbuf_r[wr_off_r] <= sh_nxt;
    end
  end

  // Output shifter; acts once per counted rising edge, so a pause never drops a bit
  always_ff @(negedge sck_i or posedge cs_n_i) begin
    if (cs_n_i) begin
      out_sh_r  <= 8'h00;
      drive_r   <= 1'b0;
      neg_tgl_r <= 1'b0;
    end else if (hold_n_i && (pos_tgl_r != neg_tgl_r)) begin
      neg_tgl_r <= pos_tgl_r;
      if (bit_r == 3'h0 && op_ok_r && op_r == `EE_OP_STAT_RD) begin
        out_sh_r <= st_s2_r;
        drive_r  <= 1'b1;
      end else if (bit_r == 3'h0 && rd_ok_r) begin
        out_sh_r <= rd_data_r;
        drive_r  <= 1'b1;
      end else begin
        out_sh_r <= {out_sh_r[6:0], 1'b0};
      end
    end
  end

  assign so_o      = out_sh_r[7];
  assign so_oe_n_o = cs_n_i | ~hold_n_i | ~drive_r;

  // Core side: pin and toggle crossings
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      cs_s1_r  <= 1'b1;
      cs_s2_r  <= 1'b1;
      cs_s3_r  <= 1'b1;
      wp_s1_r  <= 1'b1;
      wp_s2_r  <= 1'b1;
      tag_s1_r <= 1'b0;
      tag_s2_r <= 1'b0;
      rd_s1_r  <= 1'b0;
      rd_s2_r  <= 1'b0;
      rd_s3_r  <= 1'b0;
    end else begin
      cs_s1_r  <= cs_n_i;
      cs_s2_r  <= cs_s1_r;
      cs_s3_r  <= cs_s2_r;
      wp_s1_r  <= wp_n_i;
      wp_s2_r  <= wp_s1_r;
      tag_s1_r <= tag_r;
      tag_s2_r <= tag_s1_r;
      rd_s1_r  <= rd_tgl_r;
      rd_s2_r  <= rd_s1_r;
      rd_s3_r  <= rd_s2_r;
    end
  end

  // Read address is held still by the serial side until the next toggle
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      rd_data_r <= 8'h00;
    end else if (rd_s2_r != rd_s3_r) begin
      rd_data_r <= mem_r[rd_addr_r];
    end
  end

  assign cs_rise   = cs_s2_r & ~cs_s3_r;
  assign cs_fall   = ~cs_s2_r & cs_s3_r;
  assign new_frame = (tag_s2_r != tag_seen_r);
  assign busy      = (state_r != ST_IDLE);
  assign go        = cs_rise && arm_r && new_frame && !busy;
  assign wp_cancel = protect_pin_enable_r && (wp_low_r || !wp_s2_r);

  always_comb begin
    case (bp_r)
      2'b01:   prot = (wr_base_r[BASE_W - 1 -: 2] == 2'b11);
      2'b10:   prot = wr_base_r[BASE_W - 1];
      2'b11:   prot = 1'b1;
      default: prot = 1'b0;
    endcase
  end

  // Selection bookkeeping: first fall after a seen high arms the device
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      hi_seen_r  <= 1'b0;
      arm_r      <= 1'b0;
      wp_low_r   <= 1'b0;
      tag_seen_r <= 1'b0;
    end else begin
      if (cs_s2_r) begin
        hi_seen_r <= 1'b1;
      end
      if (cs_fall && hi_seen_r) begin
        arm_r <= 1'b1;
      end
      if (cs_fall) begin
        wp_low_r <= 1'b0;
      end else if (!cs_s2_r && !wp_s2_r) begin
        wp_low_r <= 1'b1;
      end
      if (cs_rise) begin
        tag_seen_r <= tag_s2_r;
      end
    end
  end

  // Write cycle sequencer; deselect has no say once it runs
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      state_r <= ST_IDLE;
      cnt_r   <= '0;
      off_r   <= '0;
    end else begin
      case (state_r)
        ST_IDLE: begin
          off_r <= '0;
          if (go && kind_r == CMD_ARRAY && wel_r && !prot) begin
            state_r <= ST_COPY;
          end else if (go && kind_r == CMD_STATUS && wel_r && !wp_cancel) begin
            state_r <= ST_WAIT;
            cnt_r   <= `EE_CNT_W'(TWC_CYCLES - 1);
          end
        end
        ST_COPY: begin
          off_r <= off_r + 1'b1;
          if (off_r == PAGE_W'(PAGE_BYTES - 1)) begin
            state_r <= ST_WAIT;
            cnt_r   <= `EE_CNT_W'(TWC_CYCLES - 1);
          end
        end
        ST_WAIT: begin
          cnt_r <= cnt_r - 1'b1;
          if (cnt_r == '0) begin
            state_r <= ST_IDLE;
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (state_r == ST_COPY && pmask_r[off_r]) begin
      mem_r[{wr_base_r, off_r}] <= pbuf_r[off_r];
    end
  end

  // Status bits; protect bits reset as a stand-in for their stored value
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      wel_r              <= 1'b0;
      {protect_pin_enable_r, bp_r}     <= `EE_NV_RST;
    end else if (state_r == ST_WAIT && cnt_r == '0) begin
      wel_r <= 1'b0;
    end else if (go && kind_r == CMD_SET) begin
      wel_r <= 1'b1;
    end else if (go && kind_r == CMD_CLR) begin
      wel_r <= 1'b0;
    end else if (go && kind_r == CMD_STATUS && wel_r && !wp_cancel) begin
      protect_pin_enable_r <= sr_byte_r[7];
      bp_r   <= sr_byte_r[3:2];
    end
  end

  assign status_o = '{protect_pin_enable: protect_pin_enable_r, spare: 3'h0, block_protect_high: bp_r[1],
                      block_protect_low: bp_r[0], write_latch_flag: wel_r,
                      write_busy_flag: busy};

  // Checks
  logic [`EE_CNT_W:0] busy_cnt_r;
  always_ff @(posedge core_clk_i) begin
    if (rst_i || !busy) begin
      busy_cnt_r <= '0;
    end else begin
      busy_cnt_r <= busy_cnt_r + 1'b1;
    end
  end

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);

  sequence s_frame_end;
    cs_rise && arm_r && new_frame && state_r == ST_IDLE;
  endsequence

  a_start_write: assert property (
    s_frame_end ##0 (kind_r == CMD_ARRAY && wel_r && !prot) |=> state_r == ST_COPY ##1 busy)
    else $error("Valid array write did not start a write cycle");
  a_block_guard: assert property (
    s_frame_end ##0 (kind_r == CMD_ARRAY && prot) |=> state_r == ST_IDLE)
    else $error("Protected block was written");
  a_wp_cancel: assert property (
    s_frame_end ##0 (kind_r == CMD_STATUS && wp_cancel) |=> !busy && $stable(bp_r))
    else $error("Status write went ahead under write protect");
  a_latch_set: assert property (
    s_frame_end ##0 kind_r == CMD_SET |=> wel_r)
    else $error("Set-latch command did not set the latch");
  a_latch_clear: assert property (
    s_frame_end ##0 kind_r == CMD_CLR |=> !wel_r)
    else $error("Clear-latch command did not clear the latch");
  a_unarmed_ignore: assert property (
    cs_rise && !arm_r |=> $stable(wel_r) && $stable(bp_r) && !busy)
    else $error("Command accepted before first selection");
  a_cycle_end: assert property (
    state_r == ST_WAIT && cnt_r == '0 |=> !wel_r && !status_o.write_busy_flag)
    else $error("Latch or busy flag not cleared at end of write");
  a_wait_holds: assert property (
    state_r == ST_WAIT && cnt_r != '0 |=> state_r == ST_WAIT && $past(cnt_r) == cnt_r + 1'b1)
    else $error("Write cycle interrupted");
  a_cycle_bound: assert property (
    busy_cnt_r <= BUSY_MAX && (busy == status_o.write_busy_flag))
    else $error("Write cycle ran too long");
  a_hold_float: assert property (
    !hold_n_i || cs_n_i |-> so_oe_n_o)
    else $error("Serial output driven while paused or deselected");

endmodule // spi_serial_eeprom_interface
`default_nettype wire

// ---- verif/ee_spi_master.sv ----
// SPI master model facing the serial EEPROM slave, mode 0
`default_nettype none
module ee_spi_master (
  output logic      sck_o,     // Serial clock, stands low outside frames
  output logic      cs_n_o,    // Chip select, active low
  output logic      si_o,      // Serial data to slave
  output logic      hold_n_o,  // Pause, active low
  input  wire logic so_i,      // Slave serial data
  input  wire logic so_oe_n_i  // Slave output enable, low while driving
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam time HALF = 80ns;
  logic last_r = 1'b0;
  logic hz_r = 1'b0;
  logic bk_r = 1'b0;
  logic so_w;
  // Undriven line shows the inverse of its last value, no pull resistor
  assign so_w = (so_oe_n_i === 1'b0) ? so_i : ~last_r;
  always @(so_i, so_oe_n_i) if (so_oe_n_i === 1'b0) last_r <= so_i;
  initial begin
    sck_o = 1'b0;
    // Late in the time step so the slave sees the rise that clears its frame state
    cs_n_o <= 1'b1;
    si_o = 1'b0;
    hold_n_o = 1'b1;
  end
  task automatic pause_sck();
    hold_n_o = 1'b0;
    #1 hz_r = so_oe_n_i;
    repeat (2) begin
      si_o = ~si_o;
      #(HALF) sck_o = 1'b1;
      #(HALF) sck_o = 1'b0;
    end
    hold_n_o = 1'b1;
    #1 bk_r = ~so_oe_n_i;
  endtask
  task automatic xfer(input logic tx[$], input int hold_at, output logic rx[$],
                      output logic drv);
    drv = 1'b0;
    rx = {};
    // Off the core clock grid; the 160 ns serial period is 40 core periods, so the phase between the two domains stays fixed
    #1.3 cs_n_o = 1'b0;
    foreach (tx[i]) begin
      si_o = tx[i];
      if (i == hold_at) pause_sck();
      #(HALF) sck_o = 1'b1;
      rx.push_back(so_w);
      if (so_oe_n_i === 1'b0) drv = 1'b1;
      #(HALF) sck_o = 1'b0;
    end
    #(HALF) cs_n_o = 1'b1;
    si_o = ~si_o;
    #(HALF);
  endtask
endmodule // ee_spi_master
`default_nettype wire

// ---- verif/spi_serial_eeprom_interface_test.sv ----
// Self-checking bench of the serial EEPROM slave
`default_nettype none
`include "ee_consts.svh"
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin n_fail++; \
  $display("BAD %0t got %h exp %h", $time, (a), (e)); end end
module spi_serial_eeprom_interface_test;
  timeunit 1ns;
  timeprecision 100ps;
  import ee_pkg::*;
  logic        core_clk_i = 1'b0;
  // Starts unknown so the rise at time zero clears the serial-side registers
  logic        rst_i;
  logic        wp_n_i = 1'b1;
  logic        sck, cs_n, si, hold_n, so, so_oe_n, drv;
  status_type  status;
  logic        tx_q[$];
  logic        rx_q[$];
  logic [7:0]  d[4];
  logic [15:0] lfsr_r = 16'd24662;
  int unsigned n_fail = 0;
  int unsigned checked = 0;
  always #2 core_clk_i = ~core_clk_i;
  // Write time cut short; still longer than two frames so busy can be probed
  spi_serial_eeprom_interface #(.TWC_CYCLES(3000)) i_dut (
    .core_clk_i(core_clk_i), .rst_i(rst_i), .sck_i(sck), .cs_n_i(cs_n), .si_i(si),
    .hold_n_i(hold_n), .wp_n_i(wp_n_i), .so_o(so), .so_oe_n_o(so_oe_n), .status_o(status));
  ee_spi_master i_mst (.sck_o(sck), .cs_n_o(cs_n), .si_o(si), .hold_n_o(hold_n),
    .so_i(so), .so_oe_n_i(so_oe_n));
  function automatic logic [15:0] lfsr_next(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  function automatic logic [7:0] rx_byte(input int n);
    logic [7:0] v;
    for (int k = 0; k < 8; k++) v = {v[6:0], rx_q[n + k]};
    return v;
  endfunction
  task automatic put(input logic [7:0] b);
    for (int k = 7; k >= 0; k--) tx_q.push_back(b[k]);
  endtask
  task automatic frame(input int hold_at);
    i_mst.xfer(tx_q, hold_at, rx_q, drv);
    tx_q = {};
    repeat (8) @(posedge core_clk_i);
  endtask
  task automatic cmd1(input logic [7:0] c);
    put(c);
    frame(-1);
  endtask
  task automatic op(input logic [7:0] c, input logic [15:0] a, input int f, input int n,
                    input int hold_at);
    put(c);
    put(a[15:8]);
    put(a[7:0]);
    for (int k = f; k < f + n; k++) put(d[k]);
    frame(hold_at);
  endtask
  task automatic swr(input logic [7:0] v);
    cmd1(`EE_OP_SET_LATCH);
    put(`EE_OP_STAT_WR);
    put(v);
    frame(-1);
  endtask
  task automatic pin(input logic v);
    @(posedge core_clk_i);
    wp_n_i <= v;
  endtask
  task automatic wait_idle();
    int n = 0;
    while (status.write_busy_flag !== 1'b0 && n < 4000) begin
      @(posedge core_clk_i);
      n++;
    end
    `CHK(status.write_busy_flag, 1'b0)
  endtask
  task automatic done(input string s);
    $display("test %s done", s);
  endtask
  task automatic stop_test();
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    #400us;
    n_fail++;
    stop_test();
  end
  initial begin
    rst_i <= 1'b1;
    repeat (8) @(posedge core_clk_i);
    rst_i <= 1'b0;
    repeat (8) @(posedge core_clk_i);
    for (int k = 0; k < 4; k++) begin
      lfsr_r = lfsr_next(lfsr_r);
      d[k] = lfsr_r[7:0];
    end
    put(`EE_OP_STAT_RD);
    put(8'h00);
    frame(-1);
    `CHK(rx_byte(8), 8'h00)
    // Second byte gives a decoded opcode the clocks it would need to drive
    put(8'h5a);
    put(8'h00);
    frame(-1);
    `CHK(drv, 1'b0)
    done("status");
    for (int w = 0; w < 2; w++) begin
      cmd1(`EE_OP_SET_LATCH);
      `CHK(status.write_latch_flag, 1'b1)
      op(`EE_OP_WRITE, w ? 16'hfffe : 16'h4000, w, 1 + 2 * w, -1);
      `CHK(status.write_busy_flag, 1'b1)
      op(`EE_OP_READ, 16'h0000, 0, 1, -1);
      `CHK(drv, 1'b0)
      put(`EE_OP_STAT_RD);
      put(8'h00);
      frame(-1);
      `CHK(rx_byte(8), 8'h03)
      wait_idle();
      `CHK(status.write_latch_flag, 1'b0)
    end
    op(`EE_OP_READ, 16'hfffe, 0, 3, 28);
    `CHK(rx_byte(24), d[1])
    `CHK(rx_byte(32), d[2])
    `CHK(rx_byte(40), d[0])
    `CHK(i_mst.hz_r, 1'b1)
    `CHK(i_mst.bk_r, 1'b1)
    op(`EE_OP_READ, 16'h3fc0, 0, 1, -1);
    `CHK(rx_byte(24), d[3])
    done("array");
    op(`EE_OP_WRITE, 16'h0000, 0, 1, -1);
    `CHK(status.write_busy_flag, 1'b0)
    // Set-latch and write in one selection: latch never set, nothing written
    put(`EE_OP_SET_LATCH);
    op(`EE_OP_WRITE, 16'h0000, 0, 1, -1);
    `CHK(status.write_busy_flag, 1'b0)
    `CHK(status.write_latch_flag, 1'b0)
    cmd1(`EE_OP_SET_LATCH);
    put(`EE_OP_WRITE);
    put(8'h00);
    put(8'h00);
    put(d[0]);
    repeat (4) tx_q.push_back(1'b1);
    frame(-1);
    `CHK(status.write_busy_flag, 1'b0)
    cmd1(`EE_OP_CLR_LATCH);
    `CHK(status.write_latch_flag, 1'b0)
    done("latch");
    swr(8'h8c);
    `CHK(status.write_busy_flag, 1'b1)
    wait_idle();
    `CHK(status, 8'h8c)
    pin(1'b0);
    swr(8'h00);
    wait_idle();
    `CHK(status.block_protect_high & status.protect_pin_enable, 1'b1)
    cmd1(`EE_OP_SET_LATCH);
    op(`EE_OP_WRITE, 16'h0000, 0, 1, -1);
    `CHK(status.write_busy_flag, 1'b0)
    pin(1'b1);
    swr(8'h00);
    wait_idle();
    `CHK(status, 8'h00)
    pin(1'b0);
    swr(8'h04);
    wait_idle();
    `CHK(status, 8'h04)
    done("protect");
    stop_test();
  end
endmodule // spi_serial_eeprom_interface_test
`default_nettype wire
